// [hw/serial_port_async_rx_tx.sv]
`timescale 1ns/100ps
`include "serial_port_map.svh"
module serial_port_async_rx_tx
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_clk_pin_in,
  output logic tx_clk_pin_out,
  output logic tx_clk_pin_oe,
  input wire logic rx_data_pin_in,
  output logic rx_data_pin_out,
  output logic rx_data_pin_oe,
  output logic irq
);

  // ****************************************
  // registers seen by software
  // ****************************************
  logic [7:0] irq_control_reg; // global and peripheral enables plus spare bits
  logic [7:0] periph_flags_reg; // spare flag bits, port flags live elsewhere
  logic [7:0] periph_irq_enables_reg; // per-source enables
  logic [7:0] rx_ctrl_reg; // writable part of rx status/control
  logic [7:0] tx_ctrl_reg; // writable part of tx status/control
  logic [7:0] baud_divisor_reg; // shared divisor
  logic [7:0] tx_buffer_reg; // holding buffer for next byte
  logic tx_buffer_full_reg; // holding buffer occupied
  logic overrun_flag_reg; // sticky overrun

  // field shortcuts
  logic port_enable, rx_nine_bit_sel, single_receive_enable, continuous_receive_enable;
  logic clock_source_sel, tx_nine_bit_sel, transmit_enable, sync_mode_sel;
  logic high_speed_baud_sel, tx_ninth_bit;
  assign port_enable = rx_ctrl_reg[`BIT_PORT_ENABLE];
  assign rx_nine_bit_sel = rx_ctrl_reg[`BIT_RX_NINE];
  assign single_receive_enable = rx_ctrl_reg[`BIT_SINGLE_RX];
  assign continuous_receive_enable = rx_ctrl_reg[`BIT_CONT_RX];
  assign clock_source_sel = tx_ctrl_reg[`BIT_CLOCK_SOURCE];
  assign tx_nine_bit_sel = tx_ctrl_reg[`BIT_TX_NINE];
  assign transmit_enable = tx_ctrl_reg[`BIT_TX_ENABLE];
  assign sync_mode_sel = tx_ctrl_reg[`BIT_SYNC_MODE];
  assign high_speed_baud_sel = tx_ctrl_reg[`BIT_HIGH_SPEED];
  assign tx_ninth_bit = tx_ctrl_reg[`BIT_TX_NINTH];

  // ****************************************
  // apb access decode
  // ****************************************
  logic access; // access phase, one wait state then answer
  logic commit; // edge at which a transfer completes
  logic [7:0] idx; // register index
  logic mapped; // index names a register
  assign access = psel && penable;
  assign commit = access && pready;
  assign idx = paddr[9:2];
  always_comb begin
    case (idx)
      `IDX_IRQ_CONTROL, `IDX_PERIPH_FLAGS, `IDX_RX_STATUS, `IDX_TX_BUFFER,
      `IDX_RX_BUFFER, `IDX_PERIPH_ENABLES, `IDX_TX_STATUS,
      `IDX_BAUD_DIVISOR: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end
  logic wr_ok, rd_ok; // accepted write or read at commit
  assign wr_ok = commit && pwrite && mapped;
  assign rd_ok = commit && !pwrite && mapped;

  // ****************************************
  // receive fifo, two entries of {framing, ninth, data}
  // ****************************************
  logic [9:0] fifo_mem [0:1]; // entry storage
  logic fifo_rd_ptr_reg; // oldest entry
  logic [1:0] fifo_count_reg; // 0..2 entries
  logic fifo_push; // from the receiver
  logic fifo_pop; // from a read of the buffer
  logic [9:0] rx_word; // word leaving the shifter
  logic [9:0] fifo_head; // entry software sees now
  logic fifo_wr_ptr;
  assign fifo_head = fifo_mem[fifo_rd_ptr_reg];
  assign fifo_wr_ptr = fifo_rd_ptr_reg ^ fifo_count_reg[0];
  assign fifo_pop = rd_ok && (idx == `IDX_RX_BUFFER) && (fifo_count_reg != 2'h0);

  // entry storage, per entry so framing and ninth bit travel with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_mem[0] <= 10'h000;
      fifo_mem[1] <= 10'h000;
    end else if (fifo_push) begin
      fifo_mem[fifo_wr_ptr] <= rx_word;
    end
  end

  // pointer and count; a pop and push may meet in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_rd_ptr_reg <= 1'b0;
      fifo_count_reg <= 2'h0;
    end else if (!continuous_receive_enable) begin
      fifo_rd_ptr_reg <= fifo_rd_ptr_reg ^ fifo_pop; // queued bytes stay readable
      fifo_count_reg <= fifo_count_reg - {1'b0, fifo_pop};
    end else begin
      if (fifo_pop) begin
        fifo_rd_ptr_reg <= ~fifo_rd_ptr_reg;
      end
      fifo_count_reg <= fifo_count_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  // ****************************************
  // baud generator, one divisor for both directions
  // ****************************************
  logic [7:0] brg_cnt_reg; // down counter
  logic [1:0] prescale_reg; // x64 to x16 reduction
  logic brg_tick; // x16 or x64 of bit rate
  logic os_tick; // x16 of bit rate
  logic brg_run;
  assign brg_run = transmit_enable || continuous_receive_enable || single_receive_enable;
  assign brg_tick = brg_run && (brg_cnt_reg == 8'h00);
  assign os_tick = brg_tick && (high_speed_baud_sel || prescale_reg == `SLOW_PRESCALE);

  // divisor reload, held in reset while nothing is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_cnt_reg <= 8'h00;
      prescale_reg <= 2'h0;
    end else if (!brg_run) begin
      brg_cnt_reg <= baud_divisor_reg;
      prescale_reg <= 2'h0;
    end else if (brg_tick) begin
      brg_cnt_reg <= baud_divisor_reg;
      prescale_reg <= prescale_reg + 2'h1;
    end else begin
      brg_cnt_reg <= brg_cnt_reg - 8'h01;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  tx_state_t tx_state_reg;
  logic [10:0] tx_shift_reg; // stop, ninth, data, start; lsb goes out first
  logic [3:0] tx_bits_reg; // bits left in frame
  logic [3:0] tx_tick_reg; // ticks within a bit
  logic tx_line_reg; // level on the pin
  logic tx_load; // holding buffer moves into shifter
  logic tx_async;
  assign tx_async = transmit_enable && port_enable && !sync_mode_sel;
  assign tx_load = tx_async && tx_buffer_full_reg && (tx_state_reg == TX_IDLE);

  // frame shifter; clearing the enable drops the frame at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_bits_reg <= 4'h0;
      tx_tick_reg <= 4'h0;
      tx_line_reg <= 1'b1;
    end else if (!tx_async) begin
      tx_state_reg <= TX_IDLE;
      tx_line_reg <= 1'b1;
      tx_tick_reg <= 4'h0;
    end else if (tx_load) begin
      // nine-bit frames carry the ninth bit, else stop follows bit 7
      tx_shift_reg <= tx_nine_bit_sel ? {1'b1, tx_ninth_bit, tx_buffer_reg, 1'b0}
                                      : {2'b11, tx_buffer_reg, 1'b0};
      tx_bits_reg <= tx_nine_bit_sel ? 4'd11 : 4'd10;
      tx_tick_reg <= 4'h0;
      tx_state_reg <= TX_SHIFT;
      tx_line_reg <= 1'b0;
    end else if (tx_state_reg == TX_SHIFT && os_tick) begin
      tx_tick_reg <= tx_tick_reg + 4'h1;
      if (tx_tick_reg == 4'hf) begin
        // one bit time ends
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bits_reg <= tx_bits_reg - 4'h1;
        tx_line_reg <= tx_shift_reg[1];
        if (tx_bits_reg == 4'h1) begin
          tx_state_reg <= TX_IDLE;
          tx_line_reg <= 1'b1;
        end
      end
    end
  end

  // holding buffer; write clears the empty flag, load into shifter sets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_reg <= `RST_ZERO;
      tx_buffer_full_reg <= 1'b0;
    end else if (wr_ok && idx == `IDX_TX_BUFFER) begin
      tx_buffer_reg <= pwdata[7:0];
      tx_buffer_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_buffer_full_reg <= 1'b0;
    end
  end

  // empty flag follows the enable, so raising it while the holding buffer is empty raises the flag
  logic tx_empty_flag;
  assign tx_empty_flag = transmit_enable && !tx_buffer_full_reg;

  // ****************************************
  // receiver
  // ****************************************
  rx_state_t rx_state_reg;
  logic [3:0] rx_tick_reg; // ticks within a bit
  logic [3:0] rx_bits_reg; // data bits gathered
  logic [8:0] rx_shift_reg; // data bits, filled from the top
  logic rx_prev_reg; // pin level one cycle ago
  logic rx_run;
  logic rx_half;
  // half duplex: in synchronous mode the async receiver is held off, busy transmitter or not
  assign rx_run = port_enable && continuous_receive_enable && !overrun_flag_reg &&
                  !sync_mode_sel;
  assign rx_half = (rx_tick_reg == (`HALF_BIT - 5'd1));

  // start search, mid-bit sampling, stop check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bits_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_data_pin_in;
      if (!rx_run) begin
        rx_state_reg <= RX_IDLE;
      end else begin
        case (rx_state_reg)
          RX_IDLE: begin
            rx_tick_reg <= 4'h0;
            rx_bits_reg <= 4'h0;
            if (rx_prev_reg && !rx_data_pin_in) begin
              rx_state_reg <= RX_START;
            end
          end
          RX_START: begin
            if (os_tick) begin
              rx_tick_reg <= rx_tick_reg + 4'h1;
              if (rx_half) begin
                // a start bit gone high at mid-bit was a glitch
                rx_state_reg <= rx_data_pin_in ? RX_IDLE : RX_DATA;
                rx_tick_reg <= 4'h0;
              end
            end
          end
          RX_DATA: begin
            if (os_tick) begin
              rx_tick_reg <= rx_tick_reg + 4'h1;
              if (rx_tick_reg == 4'hf) begin
                rx_bits_reg <= rx_bits_reg + 4'h1;
                if (rx_bits_reg == (rx_nine_bit_sel ? 4'd9 : 4'd8)) begin
                  rx_state_reg <= RX_IDLE; // stop bit sampled
                end else begin
                  rx_shift_reg <= {rx_data_pin_in, rx_shift_reg[8:1]};
                end
              end
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // stop bit event and the word it completes
  logic rx_stop;
  assign rx_stop = rx_run && rx_state_reg == RX_DATA && os_tick && rx_tick_reg == 4'hf &&
                   rx_bits_reg == (rx_nine_bit_sel ? 4'd9 : 4'd8);
  // eight-bit frames sit one place high in the shifter
  assign rx_word = rx_nine_bit_sel ? {!rx_data_pin_in, rx_shift_reg}
                                   : {!rx_data_pin_in, 1'b0, rx_shift_reg[8:1]};
  // a pop in the same cycle frees a slot
  assign fifo_push = rx_stop && (fifo_count_reg != 2'h2 || fifo_pop);

  // overrun is sticky until the continuous enable goes low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_flag_reg <= 1'b0;
    end else begin
      if (rx_stop && !fifo_push) begin
        overrun_flag_reg <= 1'b1;
      end else if (!continuous_receive_enable) begin
        overrun_flag_reg <= 1'b0;
      end
    end
  end

  logic rx_ready_flag;
  assign rx_ready_flag = (fifo_count_reg != 2'h0);

  // ****************************************
  // software writes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_reg <= `RST_ZERO;
      periph_flags_reg <= `RST_ZERO;
      periph_irq_enables_reg <= `RST_ZERO;
      rx_ctrl_reg <= `RST_ZERO;
      tx_ctrl_reg <= `RST_TX_STATUS;
      baud_divisor_reg <= `RST_ZERO;
    end else if (wr_ok) begin
      case (idx)
        `IDX_IRQ_CONTROL: irq_control_reg <= pwdata[7:0];
        `IDX_PERIPH_FLAGS: periph_flags_reg <= pwdata[7:0];
        `IDX_PERIPH_ENABLES: periph_irq_enables_reg <= pwdata[7:0];
        // status bits of the port are not stored here
        `IDX_RX_STATUS: rx_ctrl_reg <= pwdata[7:0] & 8'hf0;
        `IDX_TX_STATUS: tx_ctrl_reg <= pwdata[7:0] & 8'hf5;
        `IDX_BAUD_DIVISOR: baud_divisor_reg <= pwdata[7:0];
        default: baud_divisor_reg <= baud_divisor_reg;
      endcase
    end
  end

  // ****************************************
  // read view
  // ****************************************
  logic [7:0] rd_val;
  always_comb begin
    case (idx)
      `IDX_IRQ_CONTROL: rd_val = irq_control_reg;
      `IDX_PERIPH_FLAGS: rd_val = {periph_flags_reg[7:6], rx_ready_flag, tx_empty_flag,
                                   periph_flags_reg[3:0]};
      // ninth bit and framing come from the head entry
      `IDX_RX_STATUS: rd_val = {rx_ctrl_reg[7:4], 1'b0, fifo_head[9], overrun_flag_reg,
                                fifo_head[8]};
      `IDX_TX_BUFFER: rd_val = tx_buffer_reg;
      `IDX_RX_BUFFER: rd_val = fifo_head[7:0];
      `IDX_PERIPH_ENABLES: rd_val = periph_irq_enables_reg;
      `IDX_TX_STATUS: rd_val = {tx_ctrl_reg[7:4], 1'b0, high_speed_baud_sel,
                                (tx_state_reg == TX_IDLE), tx_ninth_bit};
      `IDX_BAUD_DIVISOR: rd_val = baud_divisor_reg;
      default: rd_val = 8'h00;
    endcase
  end

  // apb answer: one wait state, data and error captured with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= (!pwrite && mapped) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // pins and interrupt
  // ****************************************
  logic sync_master;
  logic sync_clk_reg; // master shift clock
  assign sync_master = port_enable && sync_mode_sel && clock_source_sel && brg_run;

  // master shift clock toggles on each baud tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_clk_reg <= 1'b1;
    end else if (sync_master && brg_tick) begin
      sync_clk_reg <= ~sync_clk_reg;
    end else if (!sync_master) begin
      sync_clk_reg <= 1'b1;
    end
  end

  // pin drivers; port enable gives the pins to the port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clk_pin_out <= 1'b1;
      tx_clk_pin_oe <= 1'b0;
      rx_data_pin_out <= 1'b1;
      rx_data_pin_oe <= 1'b0;
    end else begin
      tx_clk_pin_out <= sync_mode_sel ? sync_clk_reg : tx_line_reg;
      tx_clk_pin_oe <= sync_master || tx_async;
      rx_data_pin_out <= 1'b1;
      // data line drives only while transmitting, never with a receive enable
      rx_data_pin_oe <= port_enable && sync_mode_sel && transmit_enable &&
                        !continuous_receive_enable && !single_receive_enable;
    end
  end

  // interrupt: per-source enables, then global and peripheral gates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_control_reg[`BIT_GLOBAL_IRQ] && irq_control_reg[`BIT_PERIPH_IRQ] &&
             ((rx_ready_flag && periph_irq_enables_reg[`BIT_RX_READY]) ||
              (tx_empty_flag && periph_irq_enables_reg[`BIT_TX_EMPTY]));
    end
  end

endmodule

// [hw/serial_port_map.svh]
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
// register indexes, byte address is four times the index
`define IDX_IRQ_CONTROL 8'h0b
`define IDX_PERIPH_FLAGS 8'h0c
`define IDX_RX_STATUS 8'h18
`define IDX_TX_BUFFER 8'h19
`define IDX_RX_BUFFER 8'h1a
`define IDX_PERIPH_ENABLES 8'h8c
`define IDX_TX_STATUS 8'h98
`define IDX_BAUD_DIVISOR 8'h99
// reset values
`define RST_TX_STATUS 8'h02
`define RST_ZERO 8'h00
// irq_control_reg fields
`define BIT_GLOBAL_IRQ 7
`define BIT_PERIPH_IRQ 6
// flag and enable fields shared by the peripheral registers
`define BIT_RX_READY 5
`define BIT_TX_EMPTY 4
// rx_status_ctrl_reg fields
`define BIT_PORT_ENABLE 7
`define BIT_RX_NINE 6
`define BIT_SINGLE_RX 5
`define BIT_CONT_RX 4
`define BIT_FRAMING 2
`define BIT_OVERRUN 1
`define BIT_RX_NINTH 0
// tx_status_ctrl_reg fields
`define BIT_CLOCK_SOURCE 7
`define BIT_TX_NINE 6
`define BIT_TX_ENABLE 5
`define BIT_SYNC_MODE 4
`define BIT_HIGH_SPEED 2
`define BIT_TX_SHIFT_EMPTY 1
`define BIT_TX_NINTH 0
// timing counts in oversample ticks; the slow prescale count is in baud ticks
`define OVERSAMPLE 5'd16
`define HALF_BIT 5'd8
`define SLOW_PRESCALE 2'd3
`endif

// [hw/serial_port_pkg.sv]
package serial_port_pkg;
  // transmitter states
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;
  // receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } rx_state_t;
endpackage

// [tb/remote_serial_node.sv]
`timescale 1ns/100ps
// ************************************************
// remote async transceiver, fixed sixteen clocks a bit
// ************************************************
module remote_serial_node (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  localparam int BIT_CYC = 16; // divisor 0 with fast baud
  initial line_out = 1'b1; // idle high
  // start, data lsb first, stop; a bad stop only on request
  task automatic send(input int nb, input logic [8:0] d, input logic stp);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge pclk) line_out <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i-1];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk) line_out <= 1'b1;
  endtask
  // sample mid-bit; ends mid-stop so a back-to-back start is not missed
  task automatic recv(input int nb, output logic [8:0] d, output logic stp, output logic ok);
    int n;
    d = 9'h0;
    n = 0;
    while (line_in !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    ok = (n < 200);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      d[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge pclk);
    stp = line_in;
  endtask
endmodule

// [tb/serial_port_monitor.sv]
`timescale 1ns/100ps
`include "serial_port_map.svh"
// ************************************************
// port checker: bus answers, irq gating, serial line timing
// ************************************************
module serial_port_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_clk_pin_out,
  input wire logic tx_clk_pin_oe,
  input wire logic irq
);
  localparam logic [11:0] A_IRQ = {2'b00, `IDX_IRQ_CONTROL, 2'b00}; // global enables
  localparam logic [11:0] A_PIE = {2'b00, `IDX_PERIPH_ENABLES, 2'b00}; // source enables
  localparam logic [11:0] A_TXS = {2'b00, `IDX_TX_STATUS, 2'b00}; // transmit control
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_done; // a read that completed cleanly
  assign rd_done = pready && !pwrite && !pslverr;
  a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer one cycle into access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_misalign_refused: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access accepted");
  a_irq_global_gate: assert property (
    rd_done && paddr == A_IRQ && prdata[7:6] != 2'b11 |-> !irq)
    else $error("irq with global enables off");
  a_irq_source_gate: assert property (
    rd_done && paddr == A_PIE && prdata[5:4] == 2'b00 |-> !irq)
    else $error("irq with source enables off");
  a_abort_release: assert property (
    pready && pwrite && !pslverr && paddr == A_TXS && !pwdata[`BIT_TX_ENABLE]
    |-> ##[1:2] !tx_clk_pin_oe)
    else $error("pin still driven after transmit disable");
  // a bit lasts at least sixteen clocks even at the fastest divisor
  a_bit_low_min: assert property (
    $fell(tx_clk_pin_out) && tx_clk_pin_oe
    |-> (!tx_clk_pin_out || !tx_clk_pin_oe)[*8] ##1 (!tx_clk_pin_out || !tx_clk_pin_oe)[*8])
    else $error("low bit shorter than sixteen clocks");
  a_bit_high_min: assert property (
    $rose(tx_clk_pin_out) && tx_clk_pin_oe
    |-> (tx_clk_pin_out || !tx_clk_pin_oe)[*8] ##1 (tx_clk_pin_out || !tx_clk_pin_oe)[*8])
    else $error("high bit shorter than sixteen clocks");
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
`include "serial_port_map.svh"
// ************************************************
// bench: bus tasks, scenarios, verdict
// ************************************************
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_clk_pin_out, tx_clk_pin_oe, rx_data_pin_out, rx_data_pin_oe, irq;
  logic tx_line, rx_line; // pin levels
  logic [31:0] rd; // last read word
  logic er; // last error response
  int n_errors = 0;
  int checks_done = 0;
  assign tx_line = tx_clk_pin_oe ? tx_clk_pin_out : 1'b1; // pull-up when released
  always #25 pclk = ~pclk;
  serial_port_async_rx_tx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clk_pin_in(tx_line), .tx_clk_pin_out(tx_clk_pin_out),
    .tx_clk_pin_oe(tx_clk_pin_oe), .rx_data_pin_in(rx_line), .rx_data_pin_out(rx_data_pin_out),
    .rx_data_pin_oe(rx_data_pin_oe), .irq(irq));
  remote_serial_node node (.pclk(pclk), .line_in(tx_line), .line_out(rx_line));
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one transfer; request held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, ad(i), d);
    chk("write error", 32'h0, {31'h0, er});
  endtask
  task automatic rc(input string nm, input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, ad(i), 8'h00);
    chk(nm, {24'h0, e}, rd & {24'hffffff, m});
  endtask
  task automatic t_reset;
    logic [7:0] idx [8];
    idx = '{`IDX_IRQ_CONTROL, `IDX_PERIPH_FLAGS, `IDX_RX_STATUS, `IDX_TX_BUFFER,
      `IDX_RX_BUFFER, `IDX_PERIPH_ENABLES, `IDX_TX_STATUS, `IDX_BAUD_DIVISOR};
    foreach (idx[k]) rc("reset value", idx[k], 8'hff, (idx[k] == `IDX_TX_STATUS) ? 8'h02 : 8'h00);
    apb(1'b0, ad(8'h33), 8'h00);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, ad(`IDX_TX_STATUS) | 12'h002, 8'hff);
    chk("misaligned error", 32'h1, {31'h0, er});
    apb(1'b1, ad(`IDX_RX_BUFFER), 8'hff); // read-only place
    rc("read-only buffer", `IDX_RX_BUFFER, 8'hff, 8'h00);
    rc("tx status kept", `IDX_TX_STATUS, 8'hff, 8'h02);
    $display("test reset done");
  endtask
  task automatic t_tx;
    logic [8:0] d;
    logic s, ok;
    wr(`IDX_BAUD_DIVISOR, 8'h00);
    wr(`IDX_RX_STATUS, 8'h80);
    rc("tx empty off", `IDX_PERIPH_FLAGS, 8'h10, 8'h00);
    wr(`IDX_TX_STATUS, 8'h24);
    rc("tx empty on", `IDX_PERIPH_FLAGS, 8'h10, 8'h10);
    wr(`IDX_TX_BUFFER, 8'ha5);
    node.recv(8, d, s, ok);
    chk("tx frame 8", {21'h0, 11'h6a5}, {21'h0, ok, s, d});
    wr(`IDX_TX_STATUS, 8'h65);
    wr(`IDX_TX_BUFFER, 8'h3c);
    wr(`IDX_TX_BUFFER, 8'h5a);
    node.recv(9, d, s, ok);
    chk("tx frame 9a", {21'h0, 11'h73c}, {21'h0, ok, s, d});
    node.recv(9, d, s, ok);
    chk("tx frame 9b", {21'h0, 11'h75a}, {21'h0, ok, s, d});
    wr(`IDX_TX_BUFFER, 8'h55);
    repeat (40) @(posedge pclk);
    wr(`IDX_TX_STATUS, 8'h04);
    repeat (2) @(posedge pclk);
    chk("pin released", 32'h0, {31'h0, tx_clk_pin_oe});
    $display("test transmit done");
  endtask
  task automatic t_rx;
    wr(`IDX_RX_STATUS, 8'h90);
    node.send(8, 9'h03c, 1'b1);
    node.send(8, 9'h0c3, 1'b0);
    node.send(8, 9'h05a, 1'b1);
    rc("ready set", `IDX_PERIPH_FLAGS, 8'h20, 8'h20);
    rc("overrun", `IDX_RX_STATUS, 8'hff, 8'h92);
    rc("rx data 1", `IDX_RX_BUFFER, 8'hff, 8'h3c);
    rc("rx status 2", `IDX_RX_STATUS, 8'hff, 8'h96);
    rc("rx data 2", `IDX_RX_BUFFER, 8'hff, 8'hc3);
    rc("ready clear", `IDX_PERIPH_FLAGS, 8'h20, 8'h00);
    node.send(8, 9'h0f0, 1'b1);
    rc("blocked", `IDX_PERIPH_FLAGS, 8'h20, 8'h00);
    wr(`IDX_RX_STATUS, 8'h80);
    wr(`IDX_RX_STATUS, 8'hd0);
    rc("overrun clear", `IDX_RX_STATUS, 8'h02, 8'h00);
    wr(`IDX_IRQ_CONTROL, 8'hc0);
    node.send(9, 9'h1a5, 1'b1);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rc("flag unmasked", `IDX_PERIPH_FLAGS, 8'h20, 8'h20);
    wr(`IDX_PERIPH_ENABLES, 8'h20);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`IDX_IRQ_CONTROL, 8'h40);
    rc("global off", `IDX_IRQ_CONTROL, 8'hc0, 8'h40);
    chk("irq gated", 32'h0, {31'h0, irq});
    rc("ninth bit", `IDX_RX_STATUS, 8'h01, 8'h01);
    rc("rx data 9", `IDX_RX_BUFFER, 8'hff, 8'ha5);
    $display("test receive done");
  endtask
  // synchronous master: pins taken, clock runs, async receiver off
  task automatic t_sync;
    logic a;
    wr(`IDX_BAUD_DIVISOR, 8'h0f); // half clock period of sixteen cycles
    wr(`IDX_RX_STATUS, 8'h80);
    wr(`IDX_TX_STATUS, 8'hb4);
    repeat (2) @(posedge pclk);
    chk("clock pin driven", 32'h1, {31'h0, tx_clk_pin_oe});
    chk("data pin driven", 32'h1, {31'h0, rx_data_pin_oe});
    a = tx_clk_pin_out;
    repeat (16) @(posedge pclk);
    chk("shift clock", {31'h0, ~a}, {31'h0, tx_clk_pin_out});
    wr(`IDX_RX_STATUS, 8'h90);
    repeat (2) @(posedge pclk);
    chk("data pin released", 32'h0, {31'h0, rx_data_pin_oe});
    node.send(8, 9'h0aa, 1'b1);
    rc("no async rx in sync", `IDX_PERIPH_FLAGS, 8'h20, 8'h00);
    $display("test sync done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_sync();
    stop_test();
  end
endmodule
bind serial_port_async_rx_tx serial_port_monitor mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_clk_pin_out(tx_clk_pin_out),
  .tx_clk_pin_oe(tx_clk_pin_oe), .irq(irq));
